// File: design/dmaif_pkg.sv
// dma event flag registers: shared constants, bus encodings and helpers
// assumes a 32-bit ahb-lite style system bus and 4 flags per channel
package dmaif_pkg;

   // =====================================================================
   // register bank placement
   localparam logic [31:0] BASE_ADDR   = 32'ha000_0000;
   localparam int          BANK_AW     = 8;
   localparam logic [7:0]  OFF_STATUS  = 8'h00;
   localparam logic [7:0]  OFF_CLEAR   = 8'h04;
   localparam logic [31:0] STATUS_RST  = 32'h0000_0000;
   localparam logic [31:0] CLEAR_RST   = 32'h0000_0000;

   // =====================================================================
   // per-channel field layout inside the status and clear words
   localparam int FLD_ANY   = 0;
   localparam int FLD_DONE  = 1;
   localparam int FLD_HALF  = 2;
   localparam int FLD_FAULT = 3;
   localparam int FLD_W     = 4;
   localparam int MAX_CHAN  = 8;

   // =====================================================================
   // bus encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic       HRESP_OKAY = 1'b0;
   localparam logic       HRESP_ERR  = 1'b1;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ERR_WAIT,
      ST_ERR_DONE
   } dmaif_bus_state_t;

   // bit position of one flag of one channel
   function automatic int flag_index(input int chan, input int fld);
      return chan * FLD_W + fld;
   endfunction

endpackage

// File: design/dmaif_chan_flags.sv
// one channel's four sticky event flags
// assumes event strobes and clear bits are synchronous one-cycle pulses
`timescale 1ns/1ps
module dmaif_chan_flags (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // hardware events
   input  wire logic       done_evt,
   input  wire logic       half_evt,
   input  wire logic       fault_evt,
   // software clear, one bit per flag
   input  wire logic [3:0] clr,
   // flags: any, done, half, fault
   output logic      [3:0] flags
);

   // =====================================================================
   // flag update
   logic [3:0] flags_r;
   logic [3:0] flags_nxt;
   wire  [3:0] set_w;

   assign set_w[dmaif_pkg::FLD_ANY]   =
      done_evt | half_evt | fault_evt;
   assign set_w[dmaif_pkg::FLD_DONE]  = done_evt;
   assign set_w[dmaif_pkg::FLD_HALF]  = half_evt;
   assign set_w[dmaif_pkg::FLD_FAULT] = fault_evt;

   // a set in the clearing cycle wins so no event is lost
   assign flags_nxt = (flags_r & ~clr) | set_w;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flags_r <= 4'h0;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   assign flags = flags_r;

   // =====================================================================
   // checks
   set_wins_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      ((set_w & clr) != 4'h0)
      |=> ((flags_r & $past(set_w & clr)) == $past(set_w & clr)))
      else $error("event lost against a same-cycle clear");

   any_follows_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      (fault_evt || half_evt || done_evt)
      |=> flags_r[dmaif_pkg::FLD_ANY])
      else $error("any-event flag not set by an event");

   clear_works_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      (clr[dmaif_pkg::FLD_FAULT] && !fault_evt)
      |=> !flags_r[dmaif_pkg::FLD_FAULT])
      else $error("fault flag survived its clear");

   hold_no_clear_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      (flags_r[dmaif_pkg::FLD_HALF] && !clr[dmaif_pkg::FLD_HALF])
      |=> flags_r[dmaif_pkg::FLD_HALF])
      else $error("halfway flag dropped without a clear");

endmodule

// File: design/dmaif_regs.sv
// dma event status and flag clear registers on the system bus
// assumes a 32-bit ahb-lite master, channel event strobes of one cycle
// and channel setup registers outside that hold the interrupt gates
`timescale 1ns/1ps
module dmaif_regs #(
   parameter int NUM_CHAN = 8
) (
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                rst,
   // system bus slave
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   // channel events from the transfer engine
   input  wire logic [NUM_CHAN-1:0] transfer_done_event,
   input  wire logic [NUM_CHAN-1:0] halfway_event,
   input  wire logic [NUM_CHAN-1:0] transfer_fault_event,
   // interrupt gates from each channel_setup_reg
   input  wire logic [NUM_CHAN-1:0] done_irq_gate,
   input  wire logic [NUM_CHAN-1:0] halfway_irq_gate,
   input  wire logic [NUM_CHAN-1:0] fault_irq_gate,
   // channel control back to the setup registers
   output logic      [NUM_CHAN-1:0] chan_disable,
   output logic      [NUM_CHAN-1:0] chan_irq
);

   localparam int SW = NUM_CHAN * dmaif_pkg::FLD_W;

   // refused at elaboration: the status word has room for eight channels
   generate
      if (NUM_CHAN < 1 || NUM_CHAN > dmaif_pkg::MAX_CHAN) begin : g_bad_chan
         $error("NUM_CHAN must lie between 1 and 8");
      end
   endgenerate

   // =====================================================================
   // address phase decode
   wire        acc_w;
   wire        in_bank_w;
   wire        bad_size_w;
   wire        ok_acc_w;
   wire [7:0]  off_w;
   wire        off_status_w;
   wire        off_clear_w;

   assign acc_w      = hsel & hready & htrans[1];
   assign in_bank_w  = haddr[31:dmaif_pkg::BANK_AW]
                     == dmaif_pkg::BASE_ADDR[31:dmaif_pkg::BANK_AW];
   assign off_w      = haddr[dmaif_pkg::BANK_AW-1:0];
   // only word accesses are served; narrower ones answer with an error
   assign bad_size_w = acc_w
                     & ((hsize != dmaif_pkg::HSIZE_WORD)
                        | (haddr[1:0] != 2'h0));
   assign ok_acc_w     = acc_w & ~bad_size_w & in_bank_w;
   assign off_status_w = off_w == dmaif_pkg::OFF_STATUS;
   assign off_clear_w  = off_w == dmaif_pkg::OFF_CLEAR;

   // =====================================================================
   // error response sequencer
   dmaif_pkg::dmaif_bus_state_t state_r;
   dmaif_pkg::dmaif_bus_state_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         dmaif_pkg::ST_IDLE: begin
            if (bad_size_w) begin
               state_nxt = dmaif_pkg::ST_ERR_WAIT;
            end
         end
         dmaif_pkg::ST_ERR_WAIT: begin
            state_nxt = dmaif_pkg::ST_ERR_DONE;
         end
         dmaif_pkg::ST_ERR_DONE: begin
            if (bad_size_w) begin
               state_nxt = dmaif_pkg::ST_ERR_WAIT;
            end else begin
               state_nxt = dmaif_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = dmaif_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r <= dmaif_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // two-cycle error: first with wait, second completing
   assign hreadyout = state_r != dmaif_pkg::ST_ERR_WAIT;
   assign hresp     = (state_r == dmaif_pkg::ST_IDLE)
                    ? dmaif_pkg::HRESP_OKAY : dmaif_pkg::HRESP_ERR;

   // =====================================================================
   // write path: clear pattern is taken in the data phase and applied
   // one cycle later, so a clear lands two edges after its address phase
   logic        wr_clear_r;
   logic [31:0] clear_r;
   logic [31:0] clear_nxt;

   // writes to the status offset select nothing and are dropped
   assign clear_nxt = wr_clear_r ? hwdata : dmaif_pkg::CLEAR_RST;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_clear_r <= 1'b0;
         clear_r    <= dmaif_pkg::CLEAR_RST;
      end else begin
         wr_clear_r <= ok_acc_w & hwrite & off_clear_w;
         clear_r    <= clear_nxt;
      end
   end

   // =====================================================================
   // channel flag storage
   // nets, since every channel drives its own slice
   wire [31:0]         status_w;
   wire [NUM_CHAN-1:0] irq_w;

   genvar c;
   generate
      for (c = 0; c < NUM_CHAN; c++) begin : g_chan
         wire [3:0] flags_w;
         dmaif_chan_flags u_flags (
            .sys_clk   (sys_clk),
            .rst       (rst),
            .done_evt  (transfer_done_event[c]),
            .half_evt  (halfway_event[c]),
            .fault_evt (transfer_fault_event[c]),
            .clr       (clear_r[c*dmaif_pkg::FLD_W +: dmaif_pkg::FLD_W]),
            .flags     (flags_w)
         );
         // four bits per channel, any/done/halfway/fault upward
         assign status_w[c*dmaif_pkg::FLD_W +: dmaif_pkg::FLD_W] =
            flags_w;

         // separate gates per event kind feed one channel line
         assign irq_w[c] =
              (flags_w[dmaif_pkg::FLD_DONE]  & done_irq_gate[c])
            | (flags_w[dmaif_pkg::FLD_HALF]  & halfway_irq_gate[c])
            | (flags_w[dmaif_pkg::FLD_FAULT] & fault_irq_gate[c]);

         layout_a: assert property (
            @(posedge sys_clk) disable iff (rst)
            transfer_done_event[c]
            |=> status_w[dmaif_pkg::flag_index(c, dmaif_pkg::FLD_DONE)]
                && status_w[dmaif_pkg::flag_index(c, dmaif_pkg::FLD_ANY)])
            else $error("done event not shown at its status bit");

         fault_disable_a: assert property (
            @(posedge sys_clk) disable iff (rst)
            transfer_fault_event[c]
            |=> chan_disable[c] && (chan_irq[c] || !fault_irq_gate[c]))
            else $error("fault did not disable the channel or gate its irq");

         disable_pulse_a: assert property (
            @(posedge sys_clk) disable iff (rst)
            !transfer_fault_event[c] |=> !chan_disable[c])
            else $error("channel disabled without a fault");

         irq_gated_a: assert property (
            @(posedge sys_clk) disable iff (rst)
            (!done_irq_gate[c] && !halfway_irq_gate[c] && !fault_irq_gate[c])
            |-> !chan_irq[c])
            else $error("channel irq raised with all gates closed");

         irq_open_a: assert property (
            @(posedge sys_clk) disable iff (rst)
            (flags_w[dmaif_pkg::FLD_HALF] && halfway_irq_gate[c])
            |-> chan_irq[c])
            else $error("open halfway gate did not raise the channel irq");
      end
      if (SW < 32) begin : g_pad
         assign status_w[31:SW] = '0;
      end
   endgenerate

   assign chan_irq = irq_w;

   // =====================================================================
   // fault handling: drop the channel enable the cycle after the fault
   logic [NUM_CHAN-1:0] chan_disable_r;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         chan_disable_r <= '0;
      end else begin
         chan_disable_r <= transfer_fault_event;
      end
   end

   assign chan_disable = chan_disable_r;

   // =====================================================================
   // read path: the status word is sampled in the address phase, so a
   // clear still in flight from the previous write is not yet visible
   logic [31:0] hrdata_r;
   logic [31:0] rdata_nxt;

   assign rdata_nxt = (ok_acc_w & ~hwrite & off_status_w)
                    ? status_w : 32'h0000_0000;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hrdata_r <= dmaif_pkg::STATUS_RST;
      end else if (acc_w) begin
         hrdata_r <= rdata_nxt;
      end
   end

   assign hrdata = hrdata_r;

   // =====================================================================
   // checks
   status_reset_a: assert property (
      @(posedge sys_clk)
      $fell(rst) |-> (status_w == dmaif_pkg::STATUS_RST))
      else $error("status word not zero after reset");

   clear_reads_zero_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      (ok_acc_w && !hwrite && off_clear_w) |=> (hrdata == 32'h0000_0000))
      else $error("clear register read returned nonzero");

   status_read_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      (ok_acc_w && !hwrite && off_status_w) |=> (hrdata == $past(status_w)))
      else $error("status read returned stale data");

   rdata_hold_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      !acc_w |=> $stable(hrdata))
      else $error("read data changed without a transfer");

   bank_decode_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      (acc_w && !in_bank_w && hwrite) |=> !wr_clear_r)
      else $error("write outside the bank reached the clear register");

   bank_read_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      (acc_w && !in_bank_w && !hwrite) |=> (hrdata == 32'h0000_0000))
      else $error("read outside the bank returned nonzero");

   okay_answer_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      ok_acc_w |=> (hreadyout && !hresp))
      else $error("word access did not get a zero-wait okay");

   status_write_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      (acc_w && hwrite && off_status_w) |=> !wr_clear_r)
      else $error("write to the status word started a clear");

   clear_path_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      (ok_acc_w && hwrite && off_clear_w) |=> wr_clear_r
      ##1 (clear_r == $past(hwdata)))
      else $error("clear pattern not applied two edges after address");

   clear_idle_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      !wr_clear_r |=> (clear_r == dmaif_pkg::CLEAR_RST))
      else $error("clear pattern active without a write");

   bad_size_err_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      bad_size_w |=> (!hreadyout && hresp) ##1 (hreadyout && hresp))
      else $error("narrow access did not get a two-cycle error");

   bad_size_nowr_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      bad_size_w |=> !wr_clear_r)
      else $error("errored access started a clear");

endmodule

// File: tb/test_dma_irq_flag_regs.sv
// self-checking bench for the dma event status and flag clear registers
// assumes zero-wait okay answers and a clear that needs one idle cycle
`timescale 1ns/1ps
module test_dma_irq_flag_regs;
   // =====================================================================
   // signals
   logic        sys_clk;
   logic        rst;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [7:0]  transfer_done_event;
   logic [7:0]  halfway_event;
   logic [7:0]  transfer_fault_event;
   logic [7:0]  done_irq_gate;
   logic [7:0]  halfway_irq_gate;
   logic [7:0]  fault_irq_gate;
   logic [7:0]  chan_disable;
   logic [7:0]  chan_irq;
   int          err_count;
   int          cmp_count;
   int          cycles;
   localparam logic [31:0] A_ST = dmaif_pkg::BASE_ADDR | 32'h0000_0000;
   localparam logic [31:0] A_CL = dmaif_pkg::BASE_ADDR | 32'h0000_0004;

   dmaif_regs #(.NUM_CHAN(8)) i_dmaif_regs (
      .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .transfer_done_event(transfer_done_event),
      .halfway_event(halfway_event),
      .transfer_fault_event(transfer_fault_event),
      .done_irq_gate(done_irq_gate), .halfway_irq_gate(halfway_irq_gate),
      .fault_irq_gate(fault_irq_gate), .chan_disable(chan_disable),
      .chan_irq(chan_irq));

   // =====================================================================
   // helpers
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t bit %b expected %b", $time, got, exp);
      end
   endtask

   task automatic addr_ph(input logic wr, input logic [31:0] a,
                          input logic [2:0] sz);
      hsel = 1'b1;
      htrans = 2'b10;
      haddr = a;
      hwrite = wr;
      hsize = sz;
      tick();
      hsel = 1'b0;
      htrans = 2'b00;
      hsize = 3'h2;
   endtask

   // the trailing idle cycle lets a clear reach the flags before a read
   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd_q);
      addr_ph(wr, a, 3'h2);
      hwdata = wd;
      @(posedge sys_clk);
      rd_q = hrdata;
      chk_bit(hreadyout & ~hresp, 1'b1);
      #1;
      tick();
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] d;
      bus(1'b0, a, 32'h0000_0000, d);
      chk_word(d, exp);
   endtask

   // an error answer: one wait cycle, then the completing error cycle;
   // the data phase offers all ones so a wrongly taken clear shows up
   task automatic err_acc(input logic wr, input logic [31:0] a,
                          input logic [2:0] sz);
      addr_ph(wr, a, sz);
      hwdata = 32'hffff_ffff;
      chk_bit(hreadyout, 1'b0);
      chk_bit(hresp, 1'b1);
      tick();
      chk_bit(hreadyout & hresp, 1'b1);
      tick();
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] wd);
      logic [31:0] d;
      bus(1'b1, a, wd, d);
   endtask

   // kind 1 done, 2 halfway, 3 fault
   task automatic set_ev(input int kind, input int ch, input logic v);
      if (kind == 1) transfer_done_event[ch] = v;
      else if (kind == 2) halfway_event[ch] = v;
      else transfer_fault_event[ch] = v;
   endtask

   // =====================================================================
   // scenarios
   task automatic t_reset();
      rd(A_ST, 32'h0000_0000);
      rd(A_CL, 32'h0000_0000);
   endtask

   task automatic t_layout();
      logic [31:0] e;
      logic        g;
      for (int c = 0; c < 8; c++) begin
         for (int k = 1; k < 4; k++) begin
            e = 32'h0000_0000;
            e[c*4] = 1'b1;
            e[c*4+k] = 1'b1;
            g = (k == 1) ? done_irq_gate[c] :
                (k == 2) ? halfway_irq_gate[c] : fault_irq_gate[c];
            set_ev(k, c, 1'b1);
            tick();
            set_ev(k, c, 1'b0);
            chk_bit(chan_irq[c], g);
            chk_bit(chan_disable[c], k == 3);
            rd(A_ST, e);
            chk_bit(chan_disable[c], 1'b0);
            wr(A_CL, e);
            rd(A_ST, 32'h0000_0000);
            chk_bit(chan_irq[c], 1'b0);
         end
      end
   endtask

   task automatic t_clear();
      transfer_done_event[0] = 1'b1;
      transfer_fault_event[3] = 1'b1;
      tick();
      transfer_done_event[0] = 1'b0;
      transfer_fault_event[3] = 1'b0;
      wr(A_ST, 32'hffff_ffff);
      rd(A_ST, 32'h0000_9003);
      rd(A_CL, 32'h0000_0000);
      wr(A_CL, 32'h0000_0002);
      rd(A_ST, 32'h0000_9001);
      // event held across the whole clear write, so it meets the clear
      transfer_fault_event[3] = 1'b1;
      wr(A_CL, 32'h0000_9000);
      transfer_fault_event[3] = 1'b0;
      rd(A_ST, 32'h0000_9001);
      wr(A_CL, 32'hffff_ffff);
      rd(A_ST, 32'h0000_0000);
   endtask

   task automatic t_bus();
      halfway_event[1] = 1'b1;
      tick();
      halfway_event[1] = 1'b0;
      rd(A_ST | 32'h0000_0100, 32'h0000_0000);
      rd(A_ST | 32'h0000_0008, 32'h0000_0000);
      wr(A_CL | 32'h0000_0100, 32'hffff_ffff);
      err_acc(1'b0, A_ST, 3'h0);
      err_acc(1'b1, A_CL, 3'h1);
      err_acc(1'b0, A_ST | 32'h0000_0001, 3'h2);
      // a transfer offered while the bus is stalled must not be taken
      hready = 1'b0;
      wr(A_CL, 32'h0000_0050);
      hready = 1'b1;
      rd(A_ST, 32'h0000_0050);
      wr(A_CL, 32'h0000_0050);
      rd(A_ST, 32'h0000_0000);
   endtask

   // a reset in mid-run must wipe flags that events have set
   task automatic t_rerst();
      transfer_done_event = 8'hff;
      tick();
      transfer_done_event = 8'h00;
      rd(A_ST, 32'h3333_3333);
      chk_bit(chan_irq[1], 1'b1);
      rst = 1'b1;
      tick();
      tick();
      rst = 1'b0;
      tick();
      chk_bit(|chan_irq, 1'b0);
      rd(A_ST, 32'h0000_0000);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // =====================================================================
   // clock, timeout and main sequence
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // ceiling well above the roughly 320 cycles the sequence needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         results();
      end
   end

   initial begin
      err_count = 0;
      cmp_count = 0;
      cycles = 0;
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      hready = 1'b1;
      transfer_done_event = 8'h00;
      halfway_event = 8'h00;
      transfer_fault_event = 8'h00;
      // each gate kind open on some channels, all closed on channel 0
      done_irq_gate = 8'h66;
      halfway_irq_gate = 8'h3c;
      fault_irq_gate = 8'haa;
      repeat (3) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      tick();
      t_reset();
      t_layout();
      t_clear();
      t_bus();
      t_rerst();
      results();
   end
endmodule
